// >>> rtl/scc_defs.vh
// Purpose: constants for the switching clock control block
// Assumes: mclk at 10 MHz; all times in ns, frequencies in kHz
// Notes: cycle counts are derived from the times and the clock rate
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

`define SCC_MCLK_KHZ 10000
`define SCC_STD_FMIN_KHZ 1000
`define SCC_STD_FMAX_KHZ 2300
`define SCC_LOW_FMIN_KHZ 260
`define SCC_LOW_FMAX_KHZ 700
`define SCC_CLAMP_FMAX_KHZ 3500
`define SCC_SYNC_MIN_PHASE_NS 150
`define SCC_SYNC_LOSS_NS 5000
`define SCC_SYNC_FAULT_NS 10000
`define SCC_OUT_LOW_NS 150
`define SCC_SPREAD_HALF_NS 454545
`define SCC_SYNC_LOCK_EDGES 2

`endif

// >>> rtl/scc_pin_filter.v
// Purpose: four-flop input conditioner for pins from outside mclk
// Assumes: input is asynchronous to mclk
// Notes: output follows once the second and third stages agree
`timescale 1ns/100ps

module scc_pin_filter (
  // clock and reset
  input wire mclk,
  input wire reset,
  // pin and conditioned level
  input wire pin,
  output reg level_r
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // a single disagreeing sample never reaches the output
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

endmodule

// >>> rtl/scc_top.v
// Purpose: switching clock source select, sync loss handling, clock output
// Assumes: analog comparators deliver pin state as digital levels
// Notes: oscillator half period is given in mclk cycles by the trim code
`timescale 1ns/100ps
`include "scc_defs.vh"

module scc_top #(
  parameter SPREAD_HALF_CYC = (`SCC_SPREAD_HALF_NS * (`SCC_MCLK_KHZ / 1000)) / 1000
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // chip control pins
  input wire chip_enable,
  input wire dim_in,
  input wire low_freq_variant,
  // program pin state and sync level on the same pin
  input wire sync_in,
  input wire freq_program_released,
  input wire freq_program_short,
  input wire [4:0] freq_program_code,
  // fault hint that would raise frequency, spread resistor detect
  input wire freq_runaway,
  input wire spread_pin_present,
  // outputs
  output reg switch_clock_out,
  output reg switch_active_r,
  output reg led_sink_on,
  output reg fault_n,
  output reg soft_start_r,
  output reg sync_mode_r
);

  localparam [31:0] STD_HALF_MIN_W = (`SCC_MCLK_KHZ + 2 * `SCC_STD_FMAX_KHZ - 1) /
                                     (2 * `SCC_STD_FMAX_KHZ);
  localparam [31:0] STD_HALF_MAX_W = `SCC_MCLK_KHZ / (2 * `SCC_STD_FMIN_KHZ);
  localparam [31:0] LOW_HALF_MIN_W = (`SCC_MCLK_KHZ + 2 * `SCC_LOW_FMAX_KHZ - 1) /
                                     (2 * `SCC_LOW_FMAX_KHZ);
  localparam [31:0] LOW_HALF_MAX_W = `SCC_MCLK_KHZ / (2 * `SCC_LOW_FMIN_KHZ);
  localparam [31:0] CLAMP_HALF_MIN_W = (`SCC_MCLK_KHZ + 2 * `SCC_CLAMP_FMAX_KHZ - 1) /
                                       (2 * `SCC_CLAMP_FMAX_KHZ);
  localparam [31:0] LOSS_CYC_W = (`SCC_SYNC_LOSS_NS * (`SCC_MCLK_KHZ / 1000)) / 1000;
  localparam [31:0] FAULT_CYC_W = (`SCC_SYNC_FAULT_NS * (`SCC_MCLK_KHZ / 1000)) / 1000;
  localparam [31:0] LOW_CYC_W = (`SCC_OUT_LOW_NS * (`SCC_MCLK_KHZ / 1000) + 999) / 1000;
  localparam [31:0] LOCK_EDGES_W = `SCC_SYNC_LOCK_EDGES;
  // full-width values above, cut to the counter widths on purpose
  localparam [4:0] STD_HALF_MIN = STD_HALF_MIN_W[4:0];
  localparam [4:0] STD_HALF_MAX = STD_HALF_MAX_W[4:0];
  localparam [4:0] LOW_HALF_MIN = LOW_HALF_MIN_W[4:0];
  localparam [4:0] LOW_HALF_MAX = LOW_HALF_MAX_W[4:0];
  localparam [4:0] CLAMP_HALF_MIN = CLAMP_HALF_MIN_W[4:0];
  localparam [6:0] LOSS_CYC = LOSS_CYC_W[6:0];
  localparam [6:0] FAULT_CYC = FAULT_CYC_W[6:0];
  localparam [1:0] LOW_CYC = LOW_CYC_W[1:0];
  localparam [1:0] LOCK_EDGES = LOCK_EDGES_W[1:0];

  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_FAULT = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning

  wire en_f;
  wire dim_f;
  wire var_f;
  wire sync_f;
  wire rel_f;
  wire short_f;
  wire run_f;
  wire spread_f;

  scc_pin_filter u_en (.mclk(mclk), .reset(reset), .pin(chip_enable), .level_r(en_f));
  scc_pin_filter u_dim (.mclk(mclk), .reset(reset), .pin(dim_in), .level_r(dim_f));
  scc_pin_filter u_var (.mclk(mclk), .reset(reset), .pin(low_freq_variant), .level_r(var_f));
  // sync phases of 150 ns span at least one mclk sample
  scc_pin_filter u_sync (.mclk(mclk), .reset(reset), .pin(sync_in), .level_r(sync_f));
  scc_pin_filter u_rel (.mclk(mclk), .reset(reset), .pin(freq_program_released),
    .level_r(rel_f));
  scc_pin_filter u_short (.mclk(mclk), .reset(reset), .pin(freq_program_short),
    .level_r(short_f));
  scc_pin_filter u_run (.mclk(mclk), .reset(reset), .pin(freq_runaway), .level_r(run_f));
  scc_pin_filter u_spr (.mclk(mclk), .reset(reset), .pin(spread_pin_present),
    .level_r(spread_f));

  ////////////////////////////////////////////////////////////////////////////
  // internal oscillator

  reg [4:0] osc_cnt_r;
  reg osc_r;
  reg spread_r;
  reg [19:0] spread_cnt_r;
  reg [4:0] half_lim;
  reg [4:0] half;

  always @* begin
    half_lim = freq_program_code;
    if (var_f) begin
      if (half_lim < LOW_HALF_MIN) half_lim = LOW_HALF_MIN;
      if (half_lim > LOW_HALF_MAX) half_lim = LOW_HALF_MAX;
    end else begin
      if (half_lim < STD_HALF_MIN) half_lim = STD_HALF_MIN;
      if (half_lim > STD_HALF_MAX) half_lim = STD_HALF_MAX;
    end
    // spreading stretches every other modulation phase by one cycle
    half = half_lim + {4'h0, spread_r & spread_f};
    // a runaway trim can never push the clock beyond the ceiling
    if (run_f && half < CLAMP_HALF_MIN) half = CLAMP_HALF_MIN;
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      osc_cnt_r <= 5'h00;
      osc_r <= 1'b0;
      spread_r <= 1'b0;
      spread_cnt_r <= 20'h00000;
    end else begin
      if (osc_cnt_r + 5'h01 >= half) begin
        osc_cnt_r <= 5'h00;
        osc_r <= ~osc_r;
      end else begin
        osc_cnt_r <= osc_cnt_r + 5'h01;
      end
      if (!spread_f) begin
        spread_cnt_r <= 20'h00000;
        spread_r <= 1'b0;
      end else if (spread_cnt_r + 20'h00001 >= SPREAD_HALF_CYC[19:0]) begin
        spread_cnt_r <= 20'h00000;
        spread_r <= ~spread_r;
      end else begin
        spread_cnt_r <= spread_cnt_r + 20'h00001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync activity and loss classification

  reg sync_prev_r;
  reg [6:0] gap_cnt_r;
  reg [1:0] edge_cnt_r;
  reg [1:0] low_cnt_r;
  reg [2:0] state_r;
  wire sync_rise = sync_f & ~sync_prev_r;
  wire sync_seen = sync_rise && edge_cnt_r + 2'h1 >= LOCK_EDGES;
  // open pin floats up through the resistor; stuck low stays below it
  wire sync_open = sync_mode_r && gap_cnt_r >= LOSS_CYC && rel_f;
  wire sync_stuck = sync_mode_r && gap_cnt_r >= FAULT_CYC && !sync_f && !rel_f;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync_prev_r <= 1'b0;
      gap_cnt_r <= 7'h00;
      edge_cnt_r <= 2'h0;
      sync_mode_r <= 1'b0;
    end else begin
      sync_prev_r <= sync_f;
      if (sync_rise) begin
        gap_cnt_r <= 7'h00;
      end else if (gap_cnt_r < FAULT_CYC) begin
        gap_cnt_r <= gap_cnt_r + 7'h01;
      end
      if (gap_cnt_r >= LOSS_CYC && !sync_rise) begin
        edge_cnt_r <= 2'h0;
      end else if (sync_rise && edge_cnt_r < LOCK_EDGES) begin
        edge_cnt_r <= edge_cnt_r + 2'h1;
      end
      if (!en_f || sync_open || sync_stuck) begin
        sync_mode_r <= 1'b0;
      end else if (sync_seen) begin
        sync_mode_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start, fault and restart sequencing

  reg [2:0] state_nxt;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_WAIT: begin
        if (short_f) state_nxt = ST_FAULT;
        else if (rel_f || sync_seen) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (sync_stuck) state_nxt = ST_FAULT;
        else if (short_f && !sync_mode_r) state_nxt = ST_FAULT;
      end
      ST_FAULT: begin
        if (!short_f && (rel_f || sync_seen)) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_WAIT;
    endcase
    if (!en_f) state_nxt = ST_WAIT;
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= ST_WAIT;
      soft_start_r <= 1'b0;
      fault_n <= 1'b1;
      switch_active_r <= 1'b0;
      led_sink_on <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // soft-start request on every entry into run, first start included
      soft_start_r <= (state_nxt == ST_RUN) && (state_r != ST_RUN);
      fault_n <= (state_nxt != ST_FAULT);
      // clock source may change under dimming; the controller times it
      switch_active_r <= (state_nxt == ST_RUN) && en_f && dim_f;
      led_sink_on <= en_f && dim_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock output

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      switch_clock_out <= 1'b0;
      low_cnt_r <= 2'h0;
    end else if (!en_f) begin
      switch_clock_out <= 1'b0;
      low_cnt_r <= 2'h0;
    end else if (sync_mode_r) begin
      if (sync_rise) begin
        switch_clock_out <= 1'b0;
        low_cnt_r <= LOW_CYC - 2'h1;
      end else if (low_cnt_r != 2'h0) begin
        low_cnt_r <= low_cnt_r - 2'h1;
      end else begin
        switch_clock_out <= 1'b1;
      end
    end else begin
      low_cnt_r <= 2'h0;
      // runs in wait and fault as well, independent of dimming
      switch_clock_out <= osc_r;
    end
  end

endmodule

// >>> tb/scc_sync_src.sv
// Purpose: program pin source: sync clock, open pin or pin held low
// Assumes: mode 0 clock, 1 open, 2 held low
// Notes: mode taken only at whole periods, so no phase is cut short;
// Notes: sync_pin edges stay on 100 ns steps, clear of the mclk rising edges; released follows mode at once
`timescale 1ns/100ps
module scc_sync_src (
  // control
  input wire logic [1:0] mode,
  // pin state
  output logic sync_pin,
  output logic released
);
  // an open pin floats up, so it reads high and released
  assign released = (mode == 2'h1);
  always begin
    if (mode == 2'h0) begin
      sync_pin = 1'h1;
      #400;
      sync_pin = 1'h0;
      #400;
    end else begin
      sync_pin = (mode == 2'h1);
      #100;
    end
  end
endmodule

// >>> tb/scc_top_properties.sv
// Purpose: port timing checks for scc_top
// Assumes: one clock domain, mclk
// Notes: gap_r counts cycles since sync_in last rose
`timescale 1ns/100ps
module scc_chk (
  // clock and reset
  input wire mclk,
  input wire reset,
  // pins
  input wire chip_enable,
  input wire dim_in,
  input wire sync_in,
  input wire freq_program_released,
  input wire freq_program_short,
  // outputs
  input wire switch_clock_out,
  input wire switch_active_r,
  input wire led_sink_on,
  input wire fault_n,
  input wire soft_start_r,
  input wire sync_mode_r
);
  reg [7:0] gap_r;
  reg sync_d_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      gap_r <= 8'hff;
      sync_d_r <= 1'h0;
    end else begin
      sync_d_r <= sync_in;
      if (sync_in && !sync_d_r) gap_r <= 8'h00;
      else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
    end
  end
  ////////////////////////////////////////
  property p_low2; sync_mode_r && $past(sync_mode_r) && $fell(switch_clock_out) |=>
    !switch_clock_out ##1 switch_clock_out; endproperty
  a_low2: assert property (p_low2) else $error("sync low pulse");
  property p_trig; sync_mode_r && $past(sync_mode_r) && $fell(switch_clock_out) |->
    $past(sync_in, 3); endproperty
  a_trig: assert property (p_trig) else $error("fall without sync rise");
  // a stuck-low loss also drops sync mode; only the released pin means open
  property p_open; $fell(sync_mode_r) && freq_program_released |->
    fault_n && gap_r >= 48 && gap_r <= 60; endproperty
  a_open: assert property (p_open) else $error("sync loss timing");
  property p_stuck; $fell(fault_n) && !freq_program_short |-> gap_r >= 98 && gap_r <= 112;
  endproperty
  a_stuck: assert property (p_stuck) else $error("stuck fault timing");
  property p_stop; !fault_n |-> !switch_active_r; endproperty
  a_stop: assert property (p_stop) else $error("switching in fault");
  property p_short; $rose(freq_program_short) && chip_enable && !sync_mode_r ##1
    freq_program_short [*6] |-> !fault_n; endproperty
  a_short: assert property (p_short) else $error("short not faulted");
  property p_restart; $rose(fault_n) |-> ##[0:2] soft_start_r; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  // pin change lands on the sinks five sampled edges later
  property p_sink; led_sink_on |-> $past(dim_in, 5) && $past(chip_enable, 5); endproperty
  a_sink: assert property (p_sink) else $error("sinks on early");
endmodule
bind scc_top scc_chk u_chk (
  .mclk(mclk),
  .reset(reset),
  .chip_enable(chip_enable),
  .dim_in(dim_in),
  .sync_in(sync_in),
  .freq_program_released(freq_program_released),
  .freq_program_short(freq_program_short),
  .switch_clock_out(switch_clock_out),
  .switch_active_r(switch_active_r),
  .led_sink_on(led_sink_on),
  .fault_n(fault_n),
  .soft_start_r(soft_start_r),
  .sync_mode_r(sync_mode_r)
);

// >>> tb/tb_scc_top.sv
// Purpose: self-checking bench for scc_top
// Assumes: scc_sync_src drives the program pin
// Notes: spread phase cut to 20 cycles
`timescale 1ns/100ps
module tb_scc_top;
  logic mclk = 1'h0, reset = 1'h1, chip_enable = 1'h0, dim_in = 1'h0;
  logic low_freq_variant = 1'h0, freq_program_short = 1'h0;
  logic freq_runaway = 1'h0, spread_pin_present = 1'h0;
  logic [4:0] freq_program_code = 5'h04;
  logic [1:0] mode = 2'h2;
  logic [31:0] seed = 32'h69c6, r;
  logic sync_in, freq_program_released, switch_clock_out, switch_active_r;
  logic led_sink_on, fault_n, soft_start_r, sync_mode_r;
  int fails = 0, num_checks = 0, hi, lo, ss_cnt = 0, ss0, n5;
  scc_top #(.SPREAD_HALF_CYC(20)) uut (
    .mclk(mclk),
    .reset(reset),
    .chip_enable(chip_enable),
    .dim_in(dim_in),
    .low_freq_variant(low_freq_variant),
    .sync_in(sync_in),
    .freq_program_released(freq_program_released),
    .freq_program_short(freq_program_short),
    .freq_program_code(freq_program_code),
    .freq_runaway(freq_runaway),
    .spread_pin_present(spread_pin_present),
    .switch_clock_out(switch_clock_out),
    .switch_active_r(switch_active_r),
    .led_sink_on(led_sink_on),
    .fault_n(fault_n),
    .soft_start_r(soft_start_r),
    .sync_mode_r(sync_mode_r)
  );
  scc_sync_src u_src (.mode(mode), .sync_pin(sync_in), .released(freq_program_released));
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (soft_start_r === 1'h1) ss_cnt++;
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_half(int c, logic lv, logic ra);
    int lb, hb, v;
    lb = lv ? 8 : 3;
    hb = lv ? 19 : 5;
    v = c < lb ? lb : (c > hb ? hb : c);
    // the runaway floor only bites if a range would allow a shorter half
    if (ra && v < 2) v = 2;
    return v;
  endfunction
  task chk_bit(string nm, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task chk_int(string nm, int e, int g);
    num_checks++;
    if (g != e) begin
      fails++;
      $display("BAD %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  // next whole high run then low run of the clock output, bounded
  task meas();
    hi = 0;
    lo = 0;
    while (switch_clock_out !== 1'h0 && hi < 200) begin @(negedge mclk); hi++; end
    while (switch_clock_out !== 1'h1 && lo < 200) begin @(negedge mclk); lo++; end
    hi = 0;
    lo = 0;
    while (switch_clock_out === 1'h1 && hi < 200) begin @(negedge mclk); hi++; end
    while (switch_clock_out === 1'h0 && lo < 200) begin @(negedge mclk); lo++; end
  endtask
  task end_of_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #3000000;
    fails++;
    end_of_test();
  end
  ////////////////////////////////////////
  initial begin
    cyc(6);
    reset <= 1'h0;
    chip_enable <= 1'h1;
    cyc(40);
    chk_bit("active", 1'h0, switch_active_r);
    chk_int("starts", 0, ss_cnt);
    // dimming stays low: the output must still run
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      freq_program_code <= (i < 2) ? {5{i[0]}} : r[4:0];
      low_freq_variant <= (i == 1) | (i > 1 & r[8]);
      freq_runaway <= (i == 0) | (i > 1 & r[9]);
      cyc(60);
      meas();
      chk_int("high", exp_half(freq_program_code, low_freq_variant, freq_runaway), hi);
      chk_int("low", exp_half(freq_program_code, low_freq_variant, freq_runaway), lo);
      chk_bit("ceiling", 1'h1, hi >= 2 && lo >= 2);
    end
    low_freq_variant <= 1'h0;
    freq_runaway <= 1'h0;
    freq_program_code <= 5'h04;
    spread_pin_present <= 1'h1;
    cyc(20);
    n5 = 0;
    repeat (8) begin
      meas();
      if (hi == 5) n5++;
      chk_bit("spread half", 1'h1, hi == 4 || hi == 5);
    end
    chk_bit("spread used", 1'h1, n5 > 0);
    spread_pin_present <= 1'h0;
    dim_in <= 1'h1;
    mode <= 2'h0;
    cyc(60);
    chk_bit("sync mode", 1'h1, sync_mode_r);
    chk_int("starts", 1, ss_cnt);
    meas();
    chk_int("sync low", 2, lo);
    chk_int("sync period", 8, hi + lo);
    mode <= 2'h1;
    cyc(80);
    chk_bit("open mode", 1'h0, sync_mode_r);
    chk_bit("open fault", 1'h1, fault_n);
    meas();
    chk_int("open half", 4, hi);
    mode <= 2'h0;
    cyc(60);
    mode <= 2'h2;
    cyc(75);
    chk_bit("early fault", 1'h1, fault_n);
    cyc(40);
    chk_bit("stuck fault", 1'h0, fault_n);
    chk_bit("stuck stop", 1'h0, switch_active_r);
    ss0 = ss_cnt;
    mode <= 2'h0;
    cyc(60);
    chk_bit("recover", 1'h1, fault_n);
    chk_int("restart", ss0 + 1, ss_cnt);
    mode <= 2'h1;
    cyc(80);
    freq_program_short <= 1'h1;
    cyc(12);
    chk_bit("short fault", 1'h0, fault_n);
    chk_bit("short stop", 1'h0, switch_active_r);
    freq_program_short <= 1'h0;
    cyc(12);
    chk_bit("short clear", 1'h1, fault_n);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      dim_in <= r[0];
      chip_enable <= r[1] | (i < 8);
      cyc(8);
      chk_bit("sinks", r[0] & (r[1] | i < 8), led_sink_on);
    end
    end_of_test();
  end
endmodule
